// >>> core/async_serial_channel.sv
/*
  Asynchronous serial channel with a classic Wishbone register port,
  a transmit data register feeding a shift register, a receive buffer with
  overrun and framing detection, and sticky interrupt pending flags.
  Assumes a single 100 MHz clock and a synchronous receive line input.
*/
// Functional notes
// - Overrun flag clears only after read-while-set.
// - Serial function, transmit disabled: pin floats.
// - Port mode: pin is general-purpose until enabled.
// - Transmit enable raises transmit-empty request at once.
// - Hand-off sets empty flag and raises request.
`timescale 1ns/1ps
module async_serial_channel import uart_pkg::*; #(
  parameter int BIT_CYCLES_P = BIT_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Serial lines
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             txd_oe_o,
  // Interrupt
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////

  logic        ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic        transmit_buffer_empty_flag_q, transmit_buffer_empty_flag_d;
  logic        rdrf_q, rdrf_d;
  logic        overrun_error_flag_q, overrun_error_flag_d;
  logic        fer_q, fer_d;
  logic        armed_q, armed_d;
  logic [7:0]  txbuf_q, txbuf_d;
  logic [7:0]  rxbuf_q, rxbuf_d;
  logic [3:0]  pend_q, pend_d;
  logic [3:0]  mask_q, mask_d;
  logic        te_prev_q, te_prev_d;
  logic        tend_prev_q, tend_prev_d;
  logic        txd_q, txd_d;
  logic        oe_q, oe_d;
  logic        irq_q, irq_d;

  logic        req;
  logic        wr_act;
  logic        rd_act;
  logic        tx_ready;
  logic        tx_line;
  logic        handoff;
  logic        tend;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_ferr;
  logic        overrun;
  logic        overrun_error_flag_clr;
  logic [3:0]  events;
  logic [7:0]  status;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_txd;
  logic        wr_pend;
  logic        wr_mask;
  logic        rd_stat;
  logic        rd_rxd;
  logic        te_rise;

  function automatic logic hit(logic [7:0] a, logic [7:0] ofs);
    return a == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: ack one cycle after the request, effects at the ack edge.

  assign req    = cyc_i && stb_i;
  assign wr_act = req && ack_q && we_i && sel_i[0];
  assign rd_act = req && ack_q && !we_i;
  assign ack_o  = ack_q;
  assign dat_o  = dat_q;

  // Per-register strobes, all qualified by the ack edge.
  assign wr_ctrl = wr_act && hit(adr_i, CTRL_OFS);
  assign wr_stat = wr_act && hit(adr_i, STAT_OFS);
  assign wr_txd  = wr_act && hit(adr_i, TXD_OFS);
  assign wr_pend = wr_act && hit(adr_i, PEND_OFS);
  assign wr_mask = wr_act && hit(adr_i, MASK_OFS);
  assign rd_stat = rd_act && hit(adr_i, STAT_OFS);
  assign rd_rxd  = rd_act && hit(adr_i, RXD_OFS);

  always_comb begin
    status         = 8'h00;
    status[S_TRANSMIT_BUFFER_EMPTY_FLAG] = transmit_buffer_empty_flag_q;
    status[S_RDRF] = rdrf_q;
    status[S_OVERRUN_ERROR_FLAG] = overrun_error_flag_q;
    status[S_FER]  = fer_q;
    status[S_TEND] = tend;
  end

  always_comb begin
    ack_d = req && !ack_q;
    dat_d = dat_q;
    if (req && !ack_q) begin
      dat_d = 32'h0000_0000;
      if (hit(adr_i, CTRL_OFS)) dat_d[7:0] = ctrl_q;
      if (hit(adr_i, STAT_OFS)) dat_d[7:0] = status;
      if (hit(adr_i, TXD_OFS))  dat_d[7:0] = txbuf_q;
      if (hit(adr_i, RXD_OFS))  dat_d[7:0] = rxbuf_q;
      if (hit(adr_i, PEND_OFS)) dat_d[3:0] = pend_q;
      if (hit(adr_i, MASK_OFS)) dat_d[3:0] = mask_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift registers.

  serial_tx_shift #(
    .BIT_CYCLES_P (BIT_CYCLES_P)
  ) u_tx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (handoff),
    .data_i  (txbuf_q),
    .ready_o (tx_ready),
    .line_o  (tx_line)
  );

  serial_rx_shift #(
    .BIT_CYCLES_P (BIT_CYCLES_P)
  ) u_rx (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .en_i        (ctrl_q[C_RE]),
    .line_i      (rxd_i),
    .valid_o     (rx_valid),
    .data_o      (rx_data),
    .frame_err_o (rx_ferr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Channel state.

  // A byte moves to the shifter as soon as the transmitter is enabled, it is idle and one is waiting.
  assign handoff  = ctrl_q[C_TE] && !transmit_buffer_empty_flag_q && tx_ready;
  // Transmit end: nothing is waiting and the shifter has sent its stop bit.
  assign tend     = transmit_buffer_empty_flag_q && tx_ready;
  assign overrun  = rx_valid && rdrf_q;
  // Enabling the transmitter offers an empty buffer at once.
  assign te_rise  = ctrl_q[C_TE] && !te_prev_q;
  // The clear needs the read-while-set arming, so a stray zero write from
  // code that never looked at the flag cannot hide an overrun.
  assign overrun_error_flag_clr = wr_stat && armed_q
                    && !dat_i[S_OVERRUN_ERROR_FLAG];

  always_comb begin
    events        = 4'h0;
    events[P_TXI] = ctrl_q[C_TIE] && (te_rise || handoff);
    events[P_RXI] = ctrl_q[C_RIE] && rx_valid && !rdrf_q;
    events[P_ERI] = ctrl_q[C_RIE] && (overrun || (rx_valid && rx_ferr));
    events[P_TEI] = ctrl_q[C_TRANSMIT_END_INTERRUPT_ENABLE_BIT] && tend && !tend_prev_q;
  end

  always_comb begin
    ctrl_d      = ctrl_q;
    transmit_buffer_empty_flag_d      = transmit_buffer_empty_flag_q;
    rdrf_d      = rdrf_q;
    overrun_error_flag_d      = overrun_error_flag_q;
    fer_d       = fer_q;
    armed_d     = armed_q;
    txbuf_d     = txbuf_q;
    rxbuf_d     = rxbuf_q;
    mask_d      = mask_q;
    te_prev_d   = ctrl_q[C_TE];
    tend_prev_d = tend;
    // Set wins over a clear written in the same cycle.
    pend_d      = pend_q | events;
    if (wr_pend) begin
      pend_d = (pend_q & ~dat_i[3:0]) | events;
    end
    if (wr_ctrl) begin
      ctrl_d = dat_i[7:0];
    end
    if (wr_mask) begin
      mask_d = dat_i[3:0];
    end
    if (handoff) begin
      transmit_buffer_empty_flag_d = 1'b1;
    end
    // A byte written in the hand-off cycle is the next one waiting.
    if (wr_txd) begin
      txbuf_d = dat_i[7:0];
      transmit_buffer_empty_flag_d  = 1'b0;
    end
    // A byte landing while the buffer is read is still an overrun: the
    // reader took the older byte and the new one found the buffer full.
    if (rd_rxd) begin
      rdrf_d = 1'b0;
    end
    if (rd_stat && overrun_error_flag_q) begin
      armed_d = 1'b1;
    end
    if (overrun_error_flag_clr) begin
      overrun_error_flag_d  = 1'b0;
      armed_d = 1'b0;
    end
    if (wr_stat && !dat_i[S_FER]) begin
      fer_d = 1'b0;
    end
    // An overrun keeps the old byte; the new one is dropped.
    if (overrun) begin
      overrun_error_flag_d = 1'b1;
    end else if (rx_valid) begin
      rxbuf_d = rx_data;
      rdrf_d  = 1'b1;
    end
    if (rx_valid && rx_ferr) begin
      fer_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and interrupt outputs, registered.

  always_comb begin
    if (ctrl_q[C_TE]) begin
      txd_d = tx_line;
      oe_d  = 1'b1;
    end else begin
      // Transmitter off: the port mode bit picks between a plain port and a
      // floating pin, the latter for the serial function.
      txd_d = ctrl_q[C_PLVL];
      oe_d  = ctrl_q[C_PMODE];
    end
    irq_d = |(pend_q & mask_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q      <= CTRL_RST;
      transmit_buffer_empty_flag_q      <= 1'b1;
      rdrf_q      <= 1'b0;
      overrun_error_flag_q      <= 1'b0;
      fer_q       <= 1'b0;
      armed_q     <= 1'b0;
      txbuf_q     <= 8'h00;
      rxbuf_q     <= 8'h00;
      pend_q      <= PEND_RST;
      mask_q      <= MASK_RST;
      te_prev_q   <= 1'b0;
      // Counted as already ended, so reset alone raises no end request.
      tend_prev_q <= 1'b1;
      txd_q       <= 1'b1;
      oe_q        <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      ctrl_q      <= ctrl_d;
      transmit_buffer_empty_flag_q      <= transmit_buffer_empty_flag_d;
      rdrf_q      <= rdrf_d;
      overrun_error_flag_q      <= overrun_error_flag_d;
      fer_q       <= fer_d;
      armed_q     <= armed_d;
      txbuf_q     <= txbuf_d;
      rxbuf_q     <= rxbuf_d;
      pend_q      <= pend_d;
      mask_q      <= mask_d;
      te_prev_q   <= te_prev_d;
      tend_prev_q <= tend_prev_d;
      txd_q       <= txd_d;
      oe_q        <= oe_d;
      irq_q       <= irq_d;
    end
  end

  assign txd_o    = txd_q;
  assign txd_oe_o = oe_q;
  assign irq_o    = irq_q;

endmodule

// >>> core/serial_rx_shift.sv
/*
  Receive shift register for 8N1 frames. Samples each bit at its middle.
  Assumes line_i is already synchronous to clk_i.
*/
`timescale 1ns/1ps
module serial_rx_shift import uart_pkg::*; #(
  parameter int BIT_CYCLES_P = BIT_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control and line
  input  wire logic       en_i,
  input  wire logic       line_i,
  // Received byte
  output logic            valid_o,
  output logic [7:0]      data_o,
  output logic            frame_err_o
);

  shift_state_t     state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0]       sh_q, sh_d;
  logic [2:0]       idx_q, idx_d;
  logic             valid_q, valid_d;
  logic [7:0]       data_q, data_d;
  logic             ferr_q, ferr_d;
  logic             prev_q, prev_d;

  assign valid_o     = valid_q;
  assign data_o      = data_q;
  assign frame_err_o = ferr_q;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + CNT_W'(1);
    sh_d    = sh_q;
    idx_d   = idx_q;
    valid_d = 1'b0;
    data_d  = data_q;
    ferr_d  = ferr_q;
    prev_d  = line_i;
    case (state_q)
      SH_IDLE: begin
        cnt_d = '0;
        // Only a fall from the high idle level starts a frame, so a line
        // still low after a broken stop bit cannot fake a new one.
        if (en_i && !line_i && prev_q) begin
          state_d = SH_START;
        end
      end
      SH_START: begin
        // A start bit that is gone by mid-bit was a glitch.
        if (span_done(cnt_q, BIT_CYCLES_P / 2)) begin
          cnt_d   = '0;
          idx_d   = 3'h0;
          state_d = line_i ? SH_IDLE : SH_DATA;
        end
      end
      SH_DATA: begin
        if (span_done(cnt_q, BIT_CYCLES_P)) begin
          cnt_d = '0;
          sh_d  = {line_i, sh_q[7:1]};
          idx_d = idx_q + 3'h1;
          if (idx_q == 3'h7) begin
            state_d = SH_STOP;
          end
        end
      end
      SH_STOP: begin
        if (span_done(cnt_q, BIT_CYCLES_P)) begin
          state_d = SH_IDLE;
          valid_d = 1'b1;
          data_d  = sh_q;
          ferr_d  = !line_i;
        end
      end
      default: state_d = SH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SH_IDLE;
      cnt_q   <= '0;
      sh_q    <= 8'h00;
      idx_q   <= 3'h0;
      valid_q <= 1'b0;
      data_q  <= 8'h00;
      ferr_q  <= 1'b0;
      prev_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      idx_q   <= idx_d;
      valid_q <= valid_d;
      data_q  <= data_d;
      ferr_q  <= ferr_d;
      prev_q  <= prev_d;
    end
  end

endmodule

// >>> core/serial_tx_shift.sv
/*
  Transmit shift register: one start bit, eight data bits LSB first and one
  stop bit. Assumes load_i is only pulsed while ready_o is high.
*/
`timescale 1ns/1ps
module serial_tx_shift import uart_pkg::*; #(
  parameter int BIT_CYCLES_P = BIT_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Byte hand-off
  input  wire logic       load_i,
  input  wire logic [7:0] data_i,
  output logic            ready_o,
  // Line
  output logic            line_o
);

  shift_state_t     state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0]       sh_q, sh_d;
  logic [2:0]       idx_q, idx_d;
  logic             line_q, line_d;

  assign ready_o = (state_q == SH_IDLE);
  assign line_o  = line_q;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + CNT_W'(1);
    sh_d    = sh_q;
    idx_d   = idx_q;
    line_d  = line_q;
    case (state_q)
      SH_IDLE: begin
        cnt_d  = '0;
        line_d = 1'b1;
        if (load_i) begin
          state_d = SH_START;
          sh_d    = data_i;
          line_d  = 1'b0;
        end
      end
      SH_START: begin
        if (span_done(cnt_q, BIT_CYCLES_P)) begin
          cnt_d   = '0;
          idx_d   = 3'h0;
          state_d = SH_DATA;
          line_d  = sh_q[0];
        end
      end
      SH_DATA: begin
        if (span_done(cnt_q, BIT_CYCLES_P)) begin
          cnt_d = '0;
          if (idx_q == 3'h7) begin
            state_d = SH_STOP;
            line_d  = 1'b1;
          end else begin
            idx_d  = idx_q + 3'h1;
            sh_d   = {1'b0, sh_q[7:1]};
            line_d = sh_q[1];
          end
        end
      end
      SH_STOP: begin
        if (span_done(cnt_q, BIT_CYCLES_P)) begin
          state_d = SH_IDLE;
        end
      end
      default: state_d = SH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SH_IDLE;
      cnt_q   <= '0;
      sh_q    <= 8'h00;
      idx_q   <= 3'h0;
      line_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      idx_q   <= idx_d;
      line_q  <= line_d;
    end
  end

endmodule

// >>> core/uart_pkg.sv
/*
  Shared constants for the asynchronous serial channel: register offsets,
  field positions, reset values, bit timing and the shifter state type.
  Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave.
*/
package uart_pkg;

  // Bit timing.
  localparam int CLK_HZ     = 100_000_000;
  localparam int BAUD_BPS   = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
  localparam int CNT_W      = 16;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] TXD_OFS  = 8'h08;
  localparam logic [7:0] RXD_OFS  = 8'h0c;
  localparam logic [7:0] PEND_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS = 8'h14;

  // Control register fields.
  localparam int C_TIE   = 7;
  localparam int C_RIE   = 6;
  localparam int C_TE    = 5;
  localparam int C_RE    = 4;
  localparam int C_PMODE = 3;
  localparam int C_TRANSMIT_END_INTERRUPT_ENABLE_BIT  = 2;
  localparam int C_PLVL  = 0;

  // Status register fields.
  localparam int S_TRANSMIT_BUFFER_EMPTY_FLAG = 7;
  localparam int S_RDRF = 6;
  localparam int S_OVERRUN_ERROR_FLAG = 5;
  localparam int S_FER  = 4;
  localparam int S_TEND = 2;

  // Pending and mask register fields.
  localparam int P_TXI = 0;
  localparam int P_RXI = 1;
  localparam int P_ERI = 2;
  localparam int P_TEI = 3;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] PEND_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;

  typedef enum logic [1:0] {
    SH_IDLE  = 2'b00,
    SH_START = 2'b01,
    SH_DATA  = 2'b11,
    SH_STOP  = 2'b10
  } shift_state_t;

  // True on the last cycle of a span of n cycles.
  function automatic logic span_done(logic [CNT_W-1:0] c, int n);
    return c == CNT_W'(n - 1);
  endfunction

endpackage

// >>> verification/async_serial_channel_properties.sv
/*
  Port checker for the serial channel. Bound to the channel top and sees
  only its ports; control and mask are rebuilt from observed writes.
*/
`timescale 1ns/1ps
module async_serial_channel_properties import uart_pkg::*; #(
  parameter int BIT_CYCLES_P = 16
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        txd_o,
  input wire logic        txd_oe_o,
  input wire logic        irq_o
);
  logic [7:0] ctl_q, ctl_d, ctl2_q, msk_q, msk_d, msk2_q;
  logic       wr;

  assign wr = ack_o && we_i && sel_i[0];

  always_comb begin
    ctl_d = (wr && adr_i == CTRL_OFS) ? dat_i[7:0] : ctl_q;
    msk_d = (wr && adr_i == MASK_OFS) ? {4'h0, dat_i[3:0]} : msk_q;
    if (rst_i) begin
      ctl_d = 8'h00;
      msk_d = 8'h00;
    end
  end

  // Pins and irq are registered once more behind the registers.
  always_ff @(posedge clk_i) begin
    ctl_q  <= ctl_d;
    msk_q  <= msk_d;
    ctl2_q <= ctl_q;
    msk2_q <= msk_q;
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_delay_a: assert property ($rose(cyc_i && stb_i) |=> ack_o)
    else $error("ack not one cycle after request");
  pin_enable_a: assert property (
    txd_oe_o == (ctl2_q[C_TE] || ctl2_q[C_PMODE]))
    else $error("pin enable wrong");
  port_level_a: assert property (
    !ctl2_q[C_TE] && ctl2_q[C_PMODE] |-> txd_o == ctl2_q[C_PLVL])
    else $error("port level wrong");
  start_bit_a: assert property (
    ctl2_q[C_TE] && $past(ctl2_q[C_TE]) && $fell(txd_o) |-> !txd_o [*8])
    else $error("start bit too short");
  upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_read_a: assert property (ack_o && adr_i > MASK_OFS |->
    dat_o == 32'h0)
    else $error("unmapped read not zero");
  irq_masked_a: assert property (msk2_q == 8'h0 |-> !irq_o)
    else $error("irq while fully masked");
  te_request_a: assert property (
    $rose(ctl_q[C_TE]) && ctl_q[C_TIE] && msk_q[P_TXI] |-> ##[1:3] irq_o)
    else $error("no request on transmit enable");
  reset_pins_a: assert property ($fell(rst_i) |->
    !ack_o && !irq_o && !txd_oe_o && txd_o)
    else $error("pins wrong after reset");

  cover property ($rose(txd_oe_o));
  cover property ($rose(irq_o));
  cover property (ctl2_q[C_TE] && $fell(txd_o));
endmodule

// >>> verification/async_serial_tx_and_overrun_bench.sv
/*
  Bench for the serial channel: a Wishbone master, a serial peer and
  fixed expected register values. Assumes one 100 MHz clock.
*/
`timescale 1ns/1ps
module async_serial_tx_and_overrun_bench import uart_pkg::*; ;
  localparam int BITP = 16;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, r, m;
  logic        ack_o, rxd_i, txd_o, txd_oe_o, irq_o, pin;
  logic [7:0]  b[4];
  int          n_errors = 0;
  int          samples_checked = 0;
  int          n;
  integer      seed = 80;

  always #5 clk_i = ~clk_i;
  // A pulled-up pin: a floating driver reads high at the peer.
  assign pin = txd_oe_o ? txd_o : 1'b1;

  async_serial_channel #(.BIT_CYCLES_P(BITP)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .rxd_i(rxd_i), .txd_o(txd_o),
    .txd_oe_o(txd_oe_o), .irq_o(irq_o));
  uart_peer #(.BIT_P(BITP)) peer_u (
    .clk_i(clk_i), .line_i(pin), .line_o(rxd_i));

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic guard(input int c, input int lim);
    if (c >= lim) begin
      n_errors++;
      summarize();
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    guard(k + 32'(ack_o !== 1'b1), 21);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, r, e);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTRL_OFS, {24'h0, CTRL_RST}, "ctrl");
    rd(STAT_OFS, 32'h84, "stat");
    rd(PEND_OFS, {28'h0, PEND_RST}, "pend");
    rd(MASK_OFS, {28'h0, MASK_RST}, "mask");
    wb(1'b1, 8'h40, 32'hff);
    rd(8'h40, 32'h0, "unmapped");
    for (int i = 0; i < 5; i++) begin
      m = (i == 4) ? 32'h0 : $random(seed) & 32'hcf;
      wb(1'b1, CTRL_OFS, m);
      rd(CTRL_OFS, m, "ctrl");
      chk("oe", 32'(txd_oe_o), 32'(m[C_PMODE]));
      if (m[C_PMODE]) chk("lvl", 32'(txd_o), 32'(m[C_PLVL]));
    end
    repeat (200) @(posedge clk_i);
    peer_u.got_q.delete();
    wb(1'b1, MASK_OFS, 32'hf);
    wb(1'b1, CTRL_OFS, 32'h80);
    wb(1'b1, CTRL_OFS, 32'ha0);
    rd(PEND_OFS, 32'h1, "pend");
    rd(STAT_OFS, 32'h84, "stat");
    chk("irq", 32'(irq_o), 32'h1);
    wb(1'b1, PEND_OFS, 32'h1);
    rd(PEND_OFS, 32'h0, "pend");
    for (int i = 0; i < 4; i++) b[i] = 8'($random(seed));
    wb(1'b1, TXD_OFS, {24'h0, b[0]});
    wb(1'b1, TXD_OFS, {24'h0, b[1]});
    rd(STAT_OFS, 32'h00, "stat");
    wb(1'b1, PEND_OFS, 32'h1);
    n = 0;
    do begin
      wb(1'b0, STAT_OFS, 32'h0);
      n++;
    end while (r[S_TRANSMIT_BUFFER_EMPTY_FLAG] !== 1'b1 && n < 100);
    guard(n, 100);
    chk("stat", r, 32'h80);
    rd(PEND_OFS, 32'h1, "pend");
    n = 0;
    while (peer_u.got_q.size() < 2 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    guard(n, 400);
    for (int i = 0; i < 2; i++) begin
      chk("frame", 32'(peer_u.got_q[i]), {23'h0, 1'b1, b[i]});
    end
    wb(1'b1, PEND_OFS, 32'hf);
    wb(1'b1, CTRL_OFS, 32'hf0);
    peer_u.send(b[2], 1'b1);
    peer_u.send(b[3], 1'b1);
    repeat (4) @(posedge clk_i);
    wb(1'b1, STAT_OFS, 32'h0);
    rd(STAT_OFS, 32'he4, "stat");
    rd(PEND_OFS, 32'h6, "pend");
    chk("irq", 32'(irq_o), 32'h1);
    rd(RXD_OFS, {24'h0, b[2]}, "rxd");
    wb(1'b1, CTRL_OFS, 32'hf0 & 32'h0b);
    rd(CTRL_OFS, 32'h0, "ctrl");
    rd(PEND_OFS, 32'h6, "pend");
    wb(1'b1, STAT_OFS, 32'h0);
    rd(STAT_OFS, 32'h84, "stat");
    wb(1'b1, PEND_OFS, 32'h6);
    rd(PEND_OFS, 32'h0, "pend");
    chk("irq", 32'(irq_o), 32'h0);
    wb(1'b1, CTRL_OFS, 32'h50);
    peer_u.send(b[0], 1'b0);
    repeat (4) @(posedge clk_i);
    rd(STAT_OFS, 32'hd4, "stat");
    rd(PEND_OFS, 32'h6, "pend");
    chk("irq", 32'(irq_o), 32'h1);
    wb(1'b1, STAT_OFS, 32'h0);
    rd(STAT_OFS, 32'hc4, "stat");
    rd(RXD_OFS, {24'h0, b[0]}, "rxd");
    summarize();
  end
endmodule

bind async_serial_channel async_serial_channel_properties #(
  .BIT_CYCLES_P(BIT_CYCLES_P)
) props_u (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .txd_o(txd_o), .txd_oe_o(txd_oe_o),
  .irq_o(irq_o));

// >>> verification/uart_peer.sv
/*
  Remote serial peer: sends 8N1 frames on the receive line and keeps
  every frame it sees on the transmit pin. Assumes one bench clock.
*/
`timescale 1ns/1ps
module uart_peer #(
  parameter int BIT_P = 16
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  logic [8:0] got_q[$];

  initial line_o = 1'b1;

  // The stop level is an argument so that a broken frame could be sent.
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      repeat (BIT_P) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask

  always begin : catch
    logic [8:0] f;
    @(negedge line_i);
    repeat (BIT_P / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_P) @(posedge clk_i);
      f[i] = line_i;
    end
    got_q.push_back(f);
  end
endmodule
